// file: standby_defines.vh
// register offsets, fields, reset values and timing for the stop-mode standby block
// Behaviour
// - reset ending stop restarts at reset vector; RAM contents are kept
// - writing stop_select_bit as 1 enters the stop state
// - standby_control_reg changes only on 8-bit dedicated-instruction writes
// - wake condition already true at stop request: no stop, continue or vector
// - stopped: general-purpose I/O lines hold their previous output state
// - stopped: PWM timer counts only with external count clock selected
// - stop entry halts the watchdog and reinitialises its count
// - converter stops in stop; software clears converter_run_bit beforehand
// - stop and idle: serial input buffers off, internal output reads low
// - only three pins or reset end stop; reset ignores masks
// - unmasked pin wake with interrupts enabled acknowledged by priority conditions
// - same/higher priority running or interrupts off: resume, request stays pending
// - masked source or macro service enabled source keeps device stopped
// - pending request acknowledged once acknowledgment conditions hold
// - wake-up waits for oscillator stabilisation before resuming
// - enabled pin restarts oscillator on its selected edge
// - stabilisation wait lasts the time set in osc_settle_time_reg
// - reset wake: oscillator restarts at reset pin rise, run after settle
`ifndef STANDBY_DEFINES_VH
`define STANDBY_DEFINES_VH

`define ADDR_STANDBY_CTRL   6'h00
`define ADDR_OSC_SETTLE     6'h04
`define ADDR_EDGE_MODE      6'h08
`define ADDR_IRQ_MASK       6'h0c
`define ADDR_IRQ_PRIO       6'h10
`define ADDR_MODE_CTRL      6'h14
`define ADDR_PERIPH_CTRL    6'h18
`define ADDR_STATUS         6'h1c

`define STANDBY_CONTROL_REG_STOP_BIT       0
`define OSC_EXT_CLK_BIT     7
`define PERIPH_CONV_BIT     0
`define PERIPH_PWM_EXT_BIT  1

`define RST_STANDBY_CTRL    8'h00
`define RST_OSC_SETTLE      8'h04
`define RST_EDGE_MODE       6'h00
`define RST_IRQ_MASK        3'h7
`define RST_MACRO_SVC       3'h0
`define RST_IRQ_PRIO        6'h3f
`define RST_PERIPH_CTRL     2'h0

`define LEVEL_LOWEST        2'h3
`define SETTLE_BASE_LOG2    5'h0c

`endif

// file: pin_sync.v
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter WIDTH    = 4,
    parameter RST_VAL  = 0
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire [WIDTH-1:0] pin_i,
    output reg  [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta;

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            meta   <= RST_VAL[WIDTH-1:0];
            sync_o <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            meta   <= pin_i;
            sync_o <= meta;
        end
    end
endmodule
`default_nettype wire

// file: settle_timer.v
// oscillator stabilisation timer: 2^(base+sel) cycles after start, then a done pulse
`timescale 1ns/1ps
`include "standby_defines.vh"
`default_nettype none
module settle_timer #(
    parameter BASE_LOG2 = `SETTLE_BASE_LOG2,
    parameter CNT_W     = 24
) (
    input  wire       clk_i,
    input  wire       rst_i,
    input  wire       start_i,
    input  wire [2:0] sel_i,
    output reg        busy_o,
    output reg        done_o
);
    reg  [CNT_W-1:0] count;
    reg  [CNT_W-1:0] target;
    wire [CNT_W-1:0] one_w = {{(CNT_W-1){1'b0}}, 1'b1};
    wire [5:0]       shamt = BASE_LOG2[5:0] + {3'h0, sel_i};

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count  <= {CNT_W{1'b0}};
            target <= {CNT_W{1'b0}};
            busy_o <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i)
            begin
                // latch the length so a register rewrite cannot stretch a running wait
                count  <= {CNT_W{1'b0}};
                target <= (one_w << shamt) - one_w;
                busy_o <= 1'b1;
            end
            else if (busy_o)
            begin
                if (count == target)
                begin
                    busy_o <= 1'b0;
                    done_o <= 1'b1;
                end
                else
                begin
                    count <= count + one_w;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: stop_mode_standby_control.v
// stop-mode standby sequencer with wishbone register slave
//
// The Wishbone slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`include "standby_defines.vh"
`default_nettype none
module stop_mode_standby_control #(
    parameter NPINS        = 3,
    parameter SETTLE_LOG2  = `SETTLE_BASE_LOG2
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             wb_cyc_i,
    input  wire             wb_stb_i,
    input  wire             wb_we_i,
    input  wire [5:0]       wb_adr_i,
    input  wire [3:0]       wb_sel_i,
    input  wire [31:0]      wb_dat_i,
    output reg  [31:0]      wb_dat_o,
    output reg              wb_ack_o,
    input  wire             mov_imm_i,
    input  wire             interrupt_enable_flag_i,
    input  wire             isr_active_i,
    input  wire [1:0]       isr_level_i,
    input  wire [NPINS-1:0] ext_irq_pin_i,
    input  wire             reset_pin_n_i,
    output reg              osc_enable_o,
    output reg              sys_clk_enable_o,
    output reg              cpu_run_o,
    output reg              cpu_reset_o,
    output reg              resume_o,
    output reg              irq_ack_o,
    output reg  [1:0]       irq_ack_id_o,
    output reg  [NPINS-1:0] irq_pending_o,
    output reg              timer16_run_o,
    output reg              watch_run_o,
    output reg              pwm_run_o,
    output reg              wdt_run_o,
    output reg              wdt_clear_o,
    output reg              conv_run_o,
    output reg              serial_in_buf_en_o,
    output reg              io_hold_o,
    output reg              ext_clock_select_o
);
    localparam [3:0] ST_RUN    = 4'b0001;
    localparam [3:0] ST_STOP   = 4'b0010;
    localparam [3:0] ST_SETTLE = 4'b0100;
    localparam [3:0] ST_PINRST = 4'b1000;

    reg  [3:0]         state;
    reg  [3:0]         next_state;
    reg  [7:0]         standby_control_reg;
    reg  [7:0]         osc_settle_time_reg;
    reg  [5:0]         ext_irq_edge_mode_reg;
    reg  [NPINS-1:0]   interrupt_mask_bit;
    reg  [NPINS-1:0]   macro_service_enable_flag;
    reg  [5:0]         irq_prio;
    reg                level3_nesting_bit;
    reg  [1:0]         periph_ctrl;
    reg  [NPINS-1:0]   pending;
    reg  [NPINS-1:0]   pin_prev;
    // remembers a pin reset until run resumes, so no ack or resume leaks out early
    reg                wake_by_reset;

    wire [NPINS-1:0]   pin_sync;
    wire               rst_pin_sync;
    wire [NPINS-1:0]   pin_edge;
    wire               settle_busy;
    wire               settle_done;

    // reset pin rides in the top bit and resets high, so no pin reset is seen at start
    pin_sync #(
        .WIDTH   (NPINS + 1),
        .RST_VAL (1 << NPINS)
    ) u_pin_sync (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .pin_i  ({reset_pin_n_i, ext_irq_pin_i}),
        .sync_o ({rst_pin_sync, pin_sync})
    );

    // per-pin valid edge: 00 falling, 01 rising, 1x both
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi = gi + 1)
        begin : g_edge
            wire rise = pin_sync[gi] & ~pin_prev[gi];
            wire fall = ~pin_sync[gi] & pin_prev[gi];
            assign pin_edge[gi] = ext_irq_edge_mode_reg[2*gi+1] ? (rise | fall) :
                                  ext_irq_edge_mode_reg[2*gi] ? rise : fall;
        end
    endgenerate

    // bus access decode; writes take effect on the cycle that raises ack
    wire bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire bus_wr    = bus_req & wb_we_i;
    wire wr_byte0  = bus_wr & wb_sel_i[0];
    wire settle_st;
    wire standby_control_reg_wr   = bus_wr & mov_imm_i & (wb_sel_i == 4'b0001) &
                     (wb_adr_i == `ADDR_STANDBY_CTRL);
    wire stop_req  = standby_control_reg_wr & wb_dat_i[`STANDBY_CONTROL_REG_STOP_BIT];

    // pick the lowest-numbered eligible pending source
    // masked or macro service sources ignored
    wire [NPINS-1:0] eligible = pending & ~interrupt_mask_bit & ~macro_service_enable_flag;
    reg  [1:0]       src;
    reg              src_valid;
    reg  [1:0]       src_level;
    integer          k;

    always @*
    begin
        src       = 2'h0;
        src_valid = 1'b0;
        for (k = NPINS - 1; k >= 0; k = k - 1)
        begin
            if (eligible[k])
            begin
                src       = k[1:0];
                src_valid = 1'b1;
            end
        end
        src_level = irq_prio[2*src +: 2];
    end

    wire ackable = interrupt_enable_flag_i & src_valid &
                   (~isr_active_i | (isr_level_i > src_level) |
                    ((isr_level_i == `LEVEL_LOWEST) & ~level3_nesting_bit));

    always @*
    begin
        next_state = state;
        case (state)
            ST_RUN:
            begin
                // no stop while a wake condition stands
                if (stop_req & ~src_valid)
                    next_state = ST_STOP;
            end
            ST_STOP:
            begin
                // unmasked pin edge restarts the oscillator
                if (|(pin_edge & ~interrupt_mask_bit & ~macro_service_enable_flag))
                    next_state = ST_SETTLE;
            end
            ST_SETTLE:
            begin
                if (settle_done)
                    next_state = ST_RUN;
            end
            ST_PINRST:
            begin
                // oscillator restarts at reset pin rise
                if (rst_pin_sync)
                    next_state = ST_SETTLE;
            end
            default:
                next_state = ST_RUN;
        endcase
        // reset pin wins regardless of masks
        if (~rst_pin_sync)
            next_state = ST_PINRST;
    end

    assign settle_st = (next_state == ST_SETTLE) & (state != ST_SETTLE);

    // eight spare counter bits cover the largest select value
    settle_timer #(
        .BASE_LOG2 (SETTLE_LOG2),
        .CNT_W     (SETTLE_LOG2 + 8)
    ) u_settle (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .start_i (settle_st),
        .sel_i   (osc_settle_time_reg[2:0]),
        .busy_o  (settle_busy),
        .done_o  (settle_done)
    );

    wire leaving  = (state == ST_SETTLE) & settle_done & ~wake_by_reset;
    wire refused  = (state == ST_RUN) & stop_req & src_valid;
    wire do_ack   = ackable & (state == ST_RUN) & ~wake_by_reset;
    wire [NPINS-1:0] ack_clr = do_ack ? ({{(NPINS-1){1'b0}}, 1'b1} << src) : {NPINS{1'b0}};
    wire [NPINS-1:0] sw_clr  = (wr_byte0 & (wb_adr_i == `ADDR_STATUS)) ?
                               wb_dat_i[4 +: NPINS] : {NPINS{1'b0}};
    wire run_next = (next_state == ST_RUN);

    always @(posedge clk_i)
    begin
        // the reset pin restores configuration like a normal reset; pending flags survive
        if (rst_i | ~rst_pin_sync)
        begin
            standby_control_reg       <= `RST_STANDBY_CTRL;
            osc_settle_time_reg       <= `RST_OSC_SETTLE;
            ext_irq_edge_mode_reg     <= `RST_EDGE_MODE;
            interrupt_mask_bit        <= `RST_IRQ_MASK;
            macro_service_enable_flag <= `RST_MACRO_SVC;
            irq_prio                  <= `RST_IRQ_PRIO;
            level3_nesting_bit        <= 1'b0;
            periph_ctrl               <= `RST_PERIPH_CTRL;
        end
        else if (wr_byte0)
        begin
            if (standby_control_reg_wr)
                standby_control_reg <= wb_dat_i[7:0];
            else if (wb_adr_i == `ADDR_OSC_SETTLE)
                osc_settle_time_reg <= wb_dat_i[7:0] & 8'h87;
            else if (wb_adr_i == `ADDR_EDGE_MODE)
                ext_irq_edge_mode_reg <= wb_dat_i[5:0];
            else if (wb_adr_i == `ADDR_IRQ_MASK)
            begin
                interrupt_mask_bit        <= wb_dat_i[NPINS-1:0];
                macro_service_enable_flag <= wb_dat_i[4 +: NPINS];
            end
            else if (wb_adr_i == `ADDR_IRQ_PRIO)
                irq_prio <= wb_dat_i[5:0];
            else if (wb_adr_i == `ADDR_MODE_CTRL)
                level3_nesting_bit <= wb_dat_i[0];
            else if (wb_adr_i == `ADDR_PERIPH_CTRL)
                periph_ctrl <= wb_dat_i[1:0];
        end
    end

    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state          <= ST_RUN;
            pending        <= {NPINS{1'b0}};
            // edge modes reset to falling, so pins that idle high fake no edge here
            pin_prev       <= {NPINS{1'b0}};
            wake_by_reset  <= 1'b0;
        end
        else
        begin
            state          <= next_state;
            pin_prev       <= pin_sync;
            if (~rst_pin_sync)
                wake_by_reset <= 1'b1;
            else if (run_next)
                wake_by_reset <= 1'b0;
            // request stays pending; a new edge beats any clear
            pending <= (pending & ~ack_clr & ~sw_clr) | pin_edge;
        end
    end

    // wishbone read data and ack; unmapped reads return zero
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0000_0000;
            if (bus_req & ~wb_we_i)
            begin
                if (wb_adr_i == `ADDR_STANDBY_CTRL)
                    wb_dat_o[7:0] <= standby_control_reg;
                else if (wb_adr_i == `ADDR_OSC_SETTLE)
                    wb_dat_o[7:0] <= osc_settle_time_reg;
                else if (wb_adr_i == `ADDR_EDGE_MODE)
                    wb_dat_o[5:0] <= ext_irq_edge_mode_reg;
                else if (wb_adr_i == `ADDR_IRQ_MASK)
                    wb_dat_o[6:0] <= {macro_service_enable_flag, 1'b0, interrupt_mask_bit};
                else if (wb_adr_i == `ADDR_IRQ_PRIO)
                    wb_dat_o[5:0] <= irq_prio;
                else if (wb_adr_i == `ADDR_MODE_CTRL)
                    wb_dat_o[0] <= level3_nesting_bit;
                else if (wb_adr_i == `ADDR_PERIPH_CTRL)
                    wb_dat_o[1:0] <= periph_ctrl;
                else if (wb_adr_i == `ADDR_STATUS)
                    // bit 3 is spare and reads zero
                    wb_dat_o[8:0] <= {settle_busy, wake_by_reset, pending, 1'b0,
                                      state == ST_RUN, state == ST_STOP, state == ST_SETTLE};
            end
        end
    end

    // outputs follow the next state so they switch with the state register
    always @(posedge clk_i)
    begin
        if (rst_i)
        begin
            osc_enable_o       <= 1'b1;
            sys_clk_enable_o   <= 1'b1;
            cpu_run_o          <= 1'b1;
            cpu_reset_o        <= 1'b0;
            resume_o           <= 1'b0;
            irq_ack_o          <= 1'b0;
            irq_ack_id_o       <= 2'h0;
            irq_pending_o      <= {NPINS{1'b0}};
            timer16_run_o      <= 1'b1;
            watch_run_o        <= 1'b1;
            pwm_run_o          <= 1'b1;
            wdt_run_o          <= 1'b1;
            wdt_clear_o        <= 1'b0;
            conv_run_o         <= 1'b0;
            serial_in_buf_en_o <= 1'b1;
            io_hold_o          <= 1'b0;
            ext_clock_select_o <= 1'b0;
        end
        else
        begin
            // system clock, CPU, 16-bit timer and watch timer halted outside run; oscillator off only in stop and pin reset
            osc_enable_o       <= (next_state != ST_STOP) & (next_state != ST_PINRST);
            sys_clk_enable_o   <= run_next;
            cpu_run_o          <= run_next;
            timer16_run_o      <= run_next;
            watch_run_o        <= run_next;
            // CPU held in reset until settled, then reset vector
            cpu_reset_o        <= ~run_next & (wake_by_reset | ~rst_pin_sync);
            // PWM keeps counting only on external clock
            pwm_run_o          <= run_next | periph_ctrl[`PERIPH_PWM_EXT_BIT];
            // watchdog halted and cleared on entry
            wdt_run_o          <= run_next;
            wdt_clear_o        <= (next_state == ST_STOP) & (state == ST_RUN);
            conv_run_o         <= run_next & periph_ctrl[`PERIPH_CONV_BIT];
            serial_in_buf_en_o <= run_next;
            io_hold_o          <= ~run_next;
            ext_clock_select_o <= osc_settle_time_reg[`OSC_EXT_CLK_BIT];
            irq_ack_o          <= do_ack;
            irq_ack_id_o       <= src;
            // continue with next instruction when not acknowledged
            resume_o           <= (leaving | refused) & ~ackable;
            irq_pending_o      <= (pending & ~ack_clr & ~sw_clr) | pin_edge;
        end
    end
endmodule
`default_nettype wire

// file: standby_props.sv
// concurrent checks on the ports of the stop-mode standby sequencer
`timescale 1ns/1ps
`default_nettype none
module standby_props #(
    parameter SETTLE_LOG2 = 2
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic interrupt_enable_flag_i,
    input wire logic reset_pin_n_i,
    input wire logic osc_enable_o,
    input wire logic sys_clk_enable_o,
    input wire logic cpu_run_o,
    input wire logic cpu_reset_o,
    input wire logic resume_o,
    input wire logic irq_ack_o,
    input wire logic timer16_run_o,
    input wire logic watch_run_o,
    input wire logic wdt_run_o,
    input wire logic wdt_clear_o,
    input wire logic conv_run_o,
    input wire logic serial_in_buf_en_o,
    input wire logic io_hold_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_bus_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus ack not a single cycle after request");
    a_stop_halts_clocks: assert property (
        !cpu_run_o |-> !sys_clk_enable_o && !timer16_run_o && !watch_run_o && !wdt_run_o)
        else $error("clock or timer running while stopped");
    a_io_hold_stop: assert property (io_hold_o != cpu_run_o)
        else $error("io hold does not follow run state");
    a_serial_buf_off: assert property (!cpu_run_o |-> !serial_in_buf_en_o)
        else $error("serial input buffer on while stopped");
    a_conv_needs_run: assert property (conv_run_o |-> cpu_run_o)
        else $error("converter running while stopped");
    a_wdt_init_stop: assert property (wdt_clear_o |-> ##[0:1] !wdt_run_o)
        else $error("watchdog cleared but still running");
    a_settle_before_run: assert property ($rose(cpu_run_o) |-> $past(osc_enable_o, 3))
        else $error("run resumed without oscillator settling");
    a_ack_needs_ie: assert property (irq_ack_o |-> $past(interrupt_enable_flag_i))
        else $error("interrupt acknowledged with interrupts disabled");
    a_resume_in_run: assert property (resume_o |-> cpu_run_o && !irq_ack_o)
        else $error("resume pulse outside run or with ack");
    a_reset_pin_stop: assert property (!reset_pin_n_i [*5] |-> cpu_reset_o && !osc_enable_o)
        else $error("reset pin low but oscillator running");
endmodule
bind stop_mode_standby_control standby_props #(.SETTLE_LOG2(SETTLE_LOG2)) chk_u (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .interrupt_enable_flag_i(interrupt_enable_flag_i),
    .reset_pin_n_i(reset_pin_n_i), .osc_enable_o(osc_enable_o),
    .sys_clk_enable_o(sys_clk_enable_o), .cpu_run_o(cpu_run_o), .cpu_reset_o(cpu_reset_o),
    .resume_o(resume_o), .irq_ack_o(irq_ack_o), .timer16_run_o(timer16_run_o),
    .watch_run_o(watch_run_o), .wdt_run_o(wdt_run_o), .wdt_clear_o(wdt_clear_o),
    .conv_run_o(conv_run_o), .serial_in_buf_en_o(serial_in_buf_en_o), .io_hold_o(io_hold_o));
`default_nettype wire

// file: cpu_partner.sv
// cpu core and interrupt controller model issuing bus cycles and standby entry
`timescale 1ns/1ps
`default_nettype none
module cpu_partner (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output var logic         cyc_o,
    output var logic         stb_o,
    output var logic         we_o,
    output var logic [5:0]   adr_o,
    output var logic [3:0]   sel_o,
    output var logic [31:0]  dat_o,
    output var logic         imm_o,
    output var logic         ie_o,
    output var logic         isr_o,
    output var logic [1:0]   lvl_o
);
    initial
    begin
        {cyc_o, stb_o, we_o, imm_o, ie_o, isr_o} = 6'h00;
        {adr_o, sel_o, lvl_o} = 12'h000;
        dat_o = 32'h5a5a5a5a;
    end

    // released data shows the inverse so a stale value never passes for a fresh one
    task automatic xfer(input logic we, input logic [5:0] a, input logic [31:0] d,
                        input logic [3:0] s, input logic im, output logic [31:0] q);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= we;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        imm_o <= im;
        @(posedge clk_i);
        while (ack_i !== 1'b1)
            @(posedge clk_i);
        q = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        imm_o <= 1'b0;
        dat_o <= ~d;
    endtask

    task automatic stop_entry(input logic [7:0] periph);
        logic [31:0] q;
        xfer(1'b1, 6'h18, {24'h0, periph & 8'hfe}, 4'h1, 1'b0, q);
        xfer(1'b1, 6'h00, 32'h1, 4'h1, 1'b1, q);
        if (ie_o)
            repeat (3) @(posedge clk_i);
    endtask

    task automatic set_cpu(input logic ie, input logic act, input logic [1:0] l);
        @(posedge clk_i);
        ie_o <= ie;
        isr_o <= act;
        lvl_o <= l;
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the stop-mode standby sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [2:0] pin = 3'b110;
    logic rpin_n = 1'b1;
    logic cyc, stb, we, imm, ie, isr, ack, osc, sclk, run, crst, resume, iack, t16, wtch;
    logic pwm, wdt, wclr, conv, sbuf, hold, external_clock_select_bit;
    logic [1:0] lvl, ack_id;
    logic [2:0] pend;
    logic [3:0] sel;
    logic [5:0] adr;
    logic [31:0] wdat, rdat, q;
    logic a, r;
    logic [1:0] id;
    int c;
    int n_fail = 0;
    int n_tests = 0;
    int cycles = 0;

    always #20 clk_i = ~clk_i;

    cpu_partner cpu_u (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat), .imm_o(imm), .ie_o(ie),
        .isr_o(isr), .lvl_o(lvl));

    stop_mode_standby_control #(.NPINS(3), .SETTLE_LOG2(2)) dut_u (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .mov_imm_i(imm),
        .interrupt_enable_flag_i(ie), .isr_active_i(isr), .isr_level_i(lvl),
        .ext_irq_pin_i(pin), .reset_pin_n_i(rpin_n), .osc_enable_o(osc),
        .sys_clk_enable_o(sclk), .cpu_run_o(run), .cpu_reset_o(crst), .resume_o(resume),
        .irq_ack_o(iack), .irq_ack_id_o(ack_id), .irq_pending_o(pend), .timer16_run_o(t16),
        .watch_run_o(wtch), .pwm_run_o(pwm), .wdt_run_o(wdt), .wdt_clear_o(wclr),
        .conv_run_o(conv), .serial_in_buf_en_o(sbuf), .io_hold_o(hold),
        .ext_clock_select_o(external_clock_select_bit));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // counts oscillator-on cycles until the core runs again
    task automatic wait_run(output int n);
        n = 0;
        for (int i = 0; i < 400 && run !== 1'b1; i++)
        begin
            @(posedge clk_i);
            n += (osc === 1'b1);
        end
    endtask

    task automatic catch_pulse(input int n, output logic ak, output logic rs, output logic [1:0] k);
        {ak, rs, k} = 4'h3;
        ak = 1'b0;
        repeat (n)
        begin
            @(posedge clk_i);
            if (iack === 1'b1)
                k = ack_id;
            ak = ak | (iack === 1'b1);
            rs = rs | (resume === 1'b1);
        end
    endtask

    task automatic t_regs();
        logic [5:0] ad [4] = '{6'h04, 6'h0c, 6'h10, 6'h20};
        logic [31:0] ev [4] = '{32'h04, 32'h07, 32'h3f, 32'h00};
        cpu_u.xfer(1'b1, 6'h20, 32'hff, 4'hf, 1'b0, q);
        foreach (ad[i])
        begin
            cpu_u.xfer(1'b0, ad[i], 32'h0, 4'hf, 1'b0, q);
            check(q, ev[i]);
        end
        cpu_u.xfer(1'b1, 6'h00, 32'h1, 4'h1, 1'b0, q);
        cpu_u.xfer(1'b1, 6'h00, 32'h1, 4'hf, 1'b1, q);
        repeat (3) @(posedge clk_i);
        check(run, 1'b1);
        cpu_u.xfer(1'b0, 6'h00, 32'h0, 4'hf, 1'b0, q);
        check(q, 32'h0);
    endtask

    task automatic t_stop_ack();
        cpu_u.set_cpu(1'b1, 1'b0, 2'h0);
        cpu_u.xfer(1'b1, 6'h04, 32'h0, 4'h1, 1'b0, q);
        cpu_u.xfer(1'b1, 6'h08, 32'h1, 4'h1, 1'b0, q);
        cpu_u.xfer(1'b1, 6'h0c, 32'h42, 4'h1, 1'b0, q);
        cpu_u.stop_entry(8'h00);
        repeat (2) @(posedge clk_i);
        check({run, osc, sclk, t16, wtch, wdt, pwm}, 7'h00);
        check({hold, sbuf}, 2'b10);
        pin <= 3'b000;
        repeat (12) @(posedge clk_i);
        check({run, osc}, 2'b00);
        pin[0] <= 1'b1;
        fork
            wait_run(c);
            catch_pulse(40, a, r, id);
        join
        check(c >= 4 && c <= 8, 1'b1);
        check({a, r, id}, 4'b1000);
        cpu_u.xfer(1'b1, 6'h1c, 32'h70, 4'h1, 1'b0, q);
    endtask

    task automatic t_hold_pending();
        cpu_u.set_cpu(1'b0, 1'b0, 2'h0);
        pin[0] <= 1'b0;
        cpu_u.stop_entry(8'h00);
        repeat (2) @(posedge clk_i);
        check(run, 1'b0);
        pin[0] <= 1'b1;
        fork
            wait_run(c);
            catch_pulse(40, a, r, id);
        join
        check({a, r, pend[0]}, 3'b011);
        cpu_u.xfer(1'b0, 6'h1c, 32'h0, 4'hf, 1'b0, q);
        check(q, 32'h14);
        fork
            catch_pulse(6, a, r, id);
            cpu_u.xfer(1'b1, 6'h00, 32'h1, 4'h1, 1'b1, q);
        join
        repeat (2) @(posedge clk_i);
        check({run, a, r}, 3'b101);
        cpu_u.set_cpu(1'b1, 1'b1, 2'h0);
        catch_pulse(6, a, r, id);
        check({a, pend[0]}, 2'b01);
        cpu_u.xfer(1'b1, 6'h14, 32'h1, 4'h1, 1'b0, q);
        cpu_u.set_cpu(1'b1, 1'b1, 2'h3);
        catch_pulse(6, a, r, id);
        check({a, pend[0]}, 2'b01);
        cpu_u.xfer(1'b1, 6'h14, 32'h0, 4'h1, 1'b0, q);
        catch_pulse(6, a, r, id);
        check({a, id}, 3'b100);
    endtask

    task automatic t_pwm_reset();
        cpu_u.xfer(1'b1, 6'h18, 32'h3, 4'h1, 1'b0, q);
        cpu_u.xfer(1'b1, 6'h04, 32'h84, 4'h1, 1'b0, q);
        @(posedge clk_i);
        check({conv, external_clock_select_bit}, 2'b11);
        cpu_u.xfer(1'b1, 6'h00, 32'h1, 4'h1, 1'b1, q);
        repeat (3) @(posedge clk_i);
        check({run, pwm, conv}, 3'b010);
        rpin_n <= 1'b0;
        repeat (6) @(posedge clk_i);
        check({crst, osc}, 2'b10);
        rpin_n <= 1'b1;
        wait_run(c);
        check({crst, c >= 64}, 2'b01);
        cpu_u.xfer(1'b0, 6'h18, 32'h0, 4'hf, 1'b0, q);
        check(q, 32'h0);
    endtask

    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    initial
    begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_stop_ack();
        t_hold_pending();
        t_pwm_reset();
        give_verdict();
    end
endmodule
`default_nettype wire
